// ===== gpost_pins.sv
// model of the pins outside the gpio group
// assumes driven pins follow the block, pulled pins the pull, the rest an outside source
`timescale 1ns/1ps
module gpost_pins (
  input wire logic [31:0] pin_out_i,
  input wire logic [31:0] pin_oe_i,
  input wire logic [31:0] pull_en_i,
  input wire logic [31:0] pull_up_i,
  input wire logic [31:0] ext_i,
  output logic [31:0] pin_o
);
  // level seen at each pad
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & pull_en_i & pull_up_i)
    | (~pin_oe_i & ~pull_en_i & ext_i);
endmodule

// ===== gpost_pkg.sv
// constants, register map and helpers of the gpio output set/toggle/input block
// assumes a 32-bit axi4-lite master and one 32-pin group per instance
package gpost_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned OFF_W = 7;
  localparam logic [OFF_W-1:0] OFF_DIR = 7'h00;
  localparam logic [OFF_W-1:0] OFF_OUT = 7'h10;
  localparam logic [OFF_W-1:0] OFF_CLR = 7'h14;
  localparam logic [OFF_W-1:0] OFF_SET = 7'h18;
  localparam logic [OFF_W-1:0] OFF_TGL = 7'h1c;
  localparam logic [OFF_W-1:0] OFF_IN = 7'h20;
  localparam logic [OFF_W-1:0] OFF_SAMPLING = 7'h24;
  localparam logic [OFF_W-1:0] OFF_PULL_EN = 7'h40;
  localparam logic [DATA_W-1:0] RST_OUT = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_IN = 32'h40000000;
  localparam logic [DATA_W-1:0] RST_CFG = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte enables widened to a bit mask
  function automatic logic [DATA_W-1:0] gpost_byte_mask(input logic [3:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction
endpackage

// ===== gpost_top.sv
// gpio group: output value with clear/set/toggle aliases, input value with samplers
// assumes an axi4-lite master on clk_sys_i and asynchronous pin inputs
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module gpost_top #(
  parameter logic [24:0] GROUP_IDX = 25'h0000000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [gpost_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [gpost_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [gpost_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [gpost_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [gpost_pkg::DATA_W-1:0] pin_in_i,
  output logic [gpost_pkg::DATA_W-1:0] pin_out_o,
  output logic [gpost_pkg::DATA_W-1:0] pin_oe_o,
  output logic [gpost_pkg::DATA_W-1:0] pull_en_o,
  output logic [gpost_pkg::DATA_W-1:0] pull_up_o
);
  import gpost_pkg::*;

  // bus state
  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // port state
  logic [DATA_W-1:0] out_q, out_d, dir_q, dir_d, pull_q, pull_d;
  logic [DATA_W-1:0] samp_q, samp_d, in_q, in_d;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;
  logic [DATA_W-1:0] pin_out_q, pin_oe_q, pull_en_q, pull_up_q;
  logic [DATA_W-1:0] pull_en_d, pull_up_d;
  // decode
  logic aw_fire, w_fire, ar_fire, do_write;
  logic w_hit, r_hit, rd_in;
  logic [OFF_W-1:0] w_off, r_off;
  logic [DATA_W-1:0] wmask, wbits, cont_mask, upd;

  always_comb
  begin
    aw_fire = s_axi_awvalid_i & awready_q;
    w_fire = s_axi_wvalid_i & wready_q;
    ar_fire = s_axi_arvalid_i & arready_q;
    do_write = aw_hold_q & w_hold_q & ~bvalid_q;
    w_off = {aw_addr_q[OFF_W-1:2], 2'b00};
    r_off = {s_axi_araddr_i[OFF_W-1:2], 2'b00};
    w_hit = aw_addr_q[ADDR_W-1:OFF_W] == GROUP_IDX;
    r_hit = s_axi_araddr_i[ADDR_W-1:OFF_W] == GROUP_IDX;
    wmask = gpost_byte_mask(w_strb_q);
    wbits = w_data_q & wmask;
    rd_in = ar_fire & r_hit & (r_off == OFF_IN);
    // write channel capture, either order
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    if (aw_fire)
    begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr_i;
    end
    if (w_fire)
    begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata_i;
      w_strb_d = s_axi_wstrb_i;
    end
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
    end
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (bvalid_q & s_axi_bready_i)
    begin
      bvalid_d = 1'b0;
    end
    // register writes
    out_d = out_q;
    dir_d = dir_q;
    pull_d = pull_q;
    samp_d = samp_q;
    if (do_write)
    begin
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (!w_hit)
      begin
        bresp_d = RESP_SLVERR;
      end
      else
      begin
        unique case (w_off)
          OFF_DIR: dir_d = (dir_q & ~wmask) | wbits;
          OFF_OUT: out_d = (out_q & ~wmask) | wbits;
          OFF_CLR: out_d = out_q & ~wbits;
          OFF_SET: out_d = out_q | wbits;
          OFF_TGL: out_d = out_q ^ wbits;
          OFF_IN: out_d = out_q;
          OFF_SAMPLING: samp_d = (samp_q & ~wmask) | wbits;
          OFF_PULL_EN: pull_d = (pull_q & ~wmask) | wbits;
          default: bresp_d = RESP_SLVERR;
        endcase
      end
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d = ~w_hold_d & ~bvalid_d;
    pull_en_d = pull_d & ~dir_d;
    pull_up_d = out_d & pull_d & ~dir_d;
    // input samplers: byte enabled if any pin asks continuous
    for (int b = 0; b < 4; b++)
    begin
      cont_mask[b*8 +: 8] = {8{|samp_q[b*8 +: 8]}};
    end
    upd = ~(s2_q ^ s3_q) & (cont_mask | {DATA_W{rd_in}});
    in_d = (in_q & ~upd) | (s3_q & upd);
    // read channel
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q & s_axi_rready_i)
    begin
      rvalid_d = 1'b0;
    end
    if (ar_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      if (!r_hit)
      begin
        rresp_d = RESP_SLVERR;
      end
      else
      begin
        unique case (r_off)
          OFF_DIR: rdata_d = dir_q;
          OFF_OUT, OFF_CLR, OFF_SET, OFF_TGL: rdata_d = out_q;
          OFF_IN: rdata_d = in_d;
          OFF_SAMPLING: rdata_d = samp_q;
          OFF_PULL_EN: rdata_d = pull_q;
          default: rresp_d = RESP_SLVERR;
        endcase
      end
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      out_q <= RST_OUT;
      dir_q <= RST_CFG;
      pull_q <= RST_CFG;
      samp_q <= RST_CFG;
      in_q <= RST_IN;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_out_q <= RST_OUT;
      pin_oe_q <= RST_CFG;
      pull_en_q <= RST_CFG;
      pull_up_q <= RST_CFG;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      out_q <= out_d;
      dir_q <= dir_d;
      pull_q <= pull_d;
      samp_q <= samp_d;
      in_q <= in_d;
      s1_q <= pin_in_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_out_q <= out_d;
      pin_oe_q <= dir_d;
      pull_en_q <= pull_en_d;
      pull_up_q <= pull_up_d;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_o = pin_oe_q;
  assign pull_en_o = pull_en_q;
  assign pull_up_o = pull_up_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic wr_set, wr_tgl;
  assign wr_set = do_write & w_hit & (w_off == OFF_SET) & (w_strb_q == 4'hf);
  assign wr_tgl = do_write & w_hit & (w_off == OFF_TGL) & (w_strb_q == 4'hf);

  chk_set_alias_or: assert property (wr_set |=> out_q == ($past(out_q) | $past(w_data_q)))
    else $error("set alias did not or into output value");
  chk_set_drives_pin: assert property (
    wr_set |=> (pin_out_o & $past(w_data_q)) == $past(w_data_q))
    else $error("set alias did not drive pins high");
  chk_set_readback: assert property (
    ar_fire && r_hit && r_off == OFF_SET |=> rvalid_q && rdata_q == $past(out_q))
    else $error("set alias read does not return output value");
  chk_set_keep: assert property (
    do_write && w_hit && w_off == OFF_SET
    |=> (out_q ^ $past(out_q)) == ($past(wbits) & ~$past(out_q)))
    else $error("set alias changed bits written as zero");
  chk_toggle_mask: assert property (
    do_write && w_hit && w_off == OFF_TGL |=> (out_q ^ $past(out_q)) == $past(wbits))
    else $error("toggle alias changed bits other than those written one");
  chk_clear_low: assert property (
    do_write && w_hit && w_off == OFF_CLR |=> (pin_out_o & $past(wbits)) == '0)
    else $error("cleared output value did not drive pins low");
  chk_input_readonly: assert property (
    do_write && w_hit && w_off == OFF_IN |=> $stable(out_q) && $stable(dir_q))
    else $error("write to input value changed port state");
  chk_demand_read: assert property (
    rd_in && samp_q[7:0] == 8'h00 && s2_q[0] == s3_q[0] |=> in_q[0] == $past(s3_q[0]))
    else $error("on-demand byte not refreshed by input read");
  chk_write_okay: assert property (
    do_write && w_hit && w_off == OFF_SET |=> bresp_q == RESP_OKAY)
    else $error("own group set write not accepted");
  chk_toggle_xor: assert property (wr_tgl |=> out_q == ($past(out_q) ^ $past(w_data_q)))
    else $error("toggle alias did not invert output value");
  chk_toggle_pull: assert property (
    wr_tgl && w_data_q[0] && pull_q[0] && !dir_q[0] |=> pull_up_o[0] != $past(pull_up_o[0]))
    else $error("toggle did not swap pull direction");
  chk_toggle_readback: assert property (
    ar_fire && r_hit && r_off == OFF_TGL |=> rdata_q == $past(out_q))
    else $error("toggle alias read does not return output value");
  chk_input_follow: assert property (
    (|samp_q[15:8] && $stable(pin_in_i[8])) [*5] |-> in_q[8] == pin_in_i[8])
    else $error("input value does not follow stable pin");
  chk_out_reset: assert property ($fell(rst_i) |-> out_q == RST_OUT && pin_out_o == RST_OUT)
    else $error("output value not zero after reset");
  chk_pull_level: assert property (pull_en_o[0] |-> pull_up_o[0] == pin_out_o[0])
    else $error("pull direction differs from output value");
  chk_demand_hold: assert property (samp_q[7:0] == 8'h00 && !rd_in |=> $stable(in_q[7:0]))
    else $error("on-demand byte updated without read");
  chk_write_one_cycle: assert property (do_write |=> bvalid_q && !aw_hold_q && !w_hold_q)
    else $error("write not completed in one cycle");
  chk_group_decode: assert property (
    do_write && !w_hit |=> bresp_q == RESP_SLVERR && $stable(out_q))
    else $error("foreign group write not refused");

  cov_set_write: cover property (wr_set ##1 bvalid_q);
  cov_toggle_write: cover property (wr_tgl ##1 bvalid_q);
  cov_input_read: cover property (rd_in ##1 rvalid_q);
  cov_pull_swap: cover property (wr_tgl && pull_en_o[0]);
  cov_group_refused: cover property (do_write && !w_hit);
endmodule

// ===== gpost_top_tb.sv
// self-checking bench of the gpio set/toggle/input group
// assumes gpost_pkg and gpost_top compiled first, pins modelled by gpost_pins
`timescale 1ns/1ps
module gpost_top_tb;
  import gpost_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, ext = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, pin_in, pin_out, pin_oe, pull_en, pull_up;
  logic [31:0] rdq[$];
  logic [1:0] rrq[$], bq[$];
  logic [31:0] exp_out = '0, lf = 32'h0000a486, d, m;
  int err_total = 0, cmp_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  gpost_top #(.GROUP_IDX(25'h0000000)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pull_en_o(pull_en), .pull_up_o(pull_up));

  gpost_pins pins_u (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pull_en_i(pull_en),
    .pull_up_i(pull_up), .ext_i(ext), .pin_o(pin_in));

  function automatic logic [31:0] lfsr_next(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] ad(logic [6:0] o);
    return {25'h0000000, o};
  endfunction

  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one write, address and data offered together, bready held until response
  task automatic wr(logic [31:0] a, logic [31:0] v, logic [3:0] s, logic [1:0] r);
    bq.push_back(r);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] e, logic [1:0] r);
    rdq.push_back(e);
    rrq.push_back(r);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // every alias reads the one output value
  task automatic rd_all();
    rd(ad(OFF_OUT), exp_out, RESP_OKAY);
    rd(ad(OFF_CLR), exp_out, RESP_OKAY);
    rd(ad(OFF_SET), exp_out, RESP_OKAY);
    rd(ad(OFF_TGL), exp_out, RESP_OKAY);
    check("pin_out", exp_out, pin_out);
  endtask

  // response watcher: oldest note against each answer
  always @(posedge clk_sys_i)
  begin
    if (bvalid === 1'b1 && bready === 1'b1)
    begin
      check("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
    end
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      check("rdata", rdq.pop_front(), rdata);
      check("rresp", {30'h0, rrq.pop_front()}, {30'h0, rresp});
    end
  end

  initial
  begin
    #(30000 * 10);
    err_total++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(ad(OFF_SET), RST_OUT, RESP_OKAY);
    rd(ad(OFF_TGL), RST_OUT, RESP_OKAY);
    $display("test reset done");
    wr(ad(OFF_SET), 32'h0000f00f, 4'hf, RESP_OKAY);
    exp_out = exp_out | 32'h0000f00f;
    rd_all();
    wr(ad(OFF_TGL), 32'hff0000ff, 4'hf, RESP_OKAY);
    exp_out = exp_out ^ 32'hff0000ff;
    rd_all();
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr_next(lf);
      d = lf;
      m = {{8{lf[3]}}, {8{lf[2]}}, {8{lf[1]}}, {8{lf[0]}}};
      wr(ad(lf[4] ? OFF_SET : OFF_TGL), d, lf[3:0], RESP_OKAY);
      exp_out = lf[4] ? (exp_out | (d & m)) : (exp_out ^ (d & m));
      rd(ad(lf[5] ? OFF_SET : OFF_TGL), exp_out, RESP_OKAY);
    end
    wr(ad(OFF_CLR), 32'h0f0f0f0f, 4'hf, RESP_OKAY);
    exp_out = exp_out & ~32'h0f0f0f0f;
    wr(ad(OFF_OUT), 32'h12345678, 4'h3, RESP_OKAY);
    exp_out = (exp_out & 32'hffff0000) | (32'h12345678 & 32'h0000ffff);
    rd_all();
    $display("test set toggle done");
    wr(ad(OFF_DIR), 32'hffff0000, 4'hf, RESP_OKAY);
    wr(ad(OFF_PULL_EN), 32'h00ff00ff, 4'hf, RESP_OKAY);
    wr(ad(OFF_SAMPLING), 32'h00000100, 4'hf, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      lf = lfsr_next(lf);
      ext <= lf;
      repeat (6) @(posedge clk_sys_i);
      check("pull_en", 32'h000000ff, pull_en);
      check("pull_up", exp_out & 32'h000000ff, pull_up);
      check("pin_oe", 32'hffff0000, pin_oe);
      rd(ad(OFF_IN), (exp_out & 32'hffff00ff) | (lf & 32'h0000ff00), RESP_OKAY);
      wr(ad(OFF_TGL), 32'hffffffff, 4'hf, RESP_OKAY);
      exp_out = ~exp_out;
    end
    $display("test pins done");
    wr(32'h00000080 | ad(OFF_SET), 32'hffffffff, 4'hf, RESP_SLVERR);
    wr(ad(7'h2c), 32'hffffffff, 4'hf, RESP_SLVERR);
    wr(ad(OFF_IN), 32'hffffffff, 4'hf, RESP_OKAY);
    rd(ad(7'h2c), 32'h00000000, RESP_SLVERR);
    rd_all();
    $display("test refusals done");
    final_report();
  end
endmodule
